// *** src/rssa_top.sv ***
// Status indication and audible alarm of the room sensor, with its registers.
// Assumes a frame decoder on mclk presents register reads and writes, and
// that sensor status inputs come from logic on mclk.
`timescale 1ns/1ps
`include "rssa_cfg.svh"
module rssa_top #(
    parameter int unsigned HALF_SEC_CYCLES = `RSSA_HALF_SEC_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register access from frame decoder
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic reg_input_space,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    input wire logic bus_frame_seen,
    // Measurements, index 0 CO2, 1 humidity, 2 temperature
    input wire logic [2:0][15:0] meas_value,
    input wire logic [2:0][15:0] alert_min,
    input wire logic [2:0][15:0] alert_max,
    input wire logic [2:0][15:0] range_min,
    input wire logic [2:0][15:0] range_max,
    input wire logic [15:0] light_lux,
    // Device conditions
    input wire logic sensor_lost,
    input wire logic bootloader_mode,
    input wire logic fw_download,
    // Indicators, alarm and controls
    output logic led_green,
    output logic led_yellow,
    output logic led_red,
    output logic alarm_out,
    output logic bus_terminator,
    output logic auto_baseline_calibration,
    output rssa_pkg::rssa_status_type status_code
);
    import rssa_pkg::*;

    rssa_led_if led_if ();

    // Configuration registers
    logic [15:0] timeout_reg, timeout_next;
    logic [15:0] term_reg, term_next;
    logic [15:0] active_reg, active_next;
    logic [15:0] standby_reg, standby_next;
    logic [15:0] mode_reg, mode_next;
    logic [15:0] source_reg, source_next;
    logic [15:0] bright_reg, bright_next;
    logic [15:0] calib_reg, calib_next;
    logic [15:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic err_reg, err_next;
    // Status, light class, timers
    rssa_status_type status_reg, status_next;
    logic [15:0] class_reg, class_next;
    logic [31:0] half_cnt_reg, half_cnt_next;
    logic blink_reg, blink_next;
    logic sec_phase_reg, sec_phase_next;
    logic [15:0] idle_sec_reg, idle_sec_next;
    logic alarm_reg, alarm_next;
    // Combinational helpers
    logic [1:0] sel_idx;
    logic [15:0] sel_value;
    logic half_tick;
    logic stale;
    logic alarm_due;

    // Register file next state; a write wins over a read in the same cycle
    always_comb
    begin
        timeout_next = timeout_reg;
        term_next = term_reg;
        active_next = active_reg;
        standby_next = standby_reg;
        mode_next = mode_reg;
        source_next = source_reg;
        bright_next = bright_reg;
        calib_next = calib_reg;
        rdata_next = rdata_reg;
        err_next = 1'b0;
        if (reg_wr)
        begin
            if (reg_input_space)
                err_next = 1'b1; // Input registers are read-only
            else
            begin
                case (reg_addr)
                    `RSSA_HR_COMM_TIMEOUT: timeout_next = reg_wdata;
                    `RSSA_HR_BUS_TERM: term_next = reg_wdata;
                    `RSSA_HR_LIGHT_ACTIVE: active_next = reg_wdata;
                    `RSSA_HR_LIGHT_STANDBY: standby_next = reg_wdata;
                    `RSSA_HR_ALARM_MODE: mode_next = reg_wdata;
                    `RSSA_HR_SOURCE_SEL: source_next = reg_wdata;
                    `RSSA_HR_BRIGHTNESS: bright_next = reg_wdata;
                    `RSSA_HR_CALIB_ENABLE: calib_next = reg_wdata;
                    default: err_next = 1'b1;
                endcase
            end
        end
        else if (reg_rd)
        begin
            rdata_next = 16'h0000;
            if (reg_input_space)
            begin
                case (reg_addr)
                    `RSSA_IR_LIGHT_LUX: rdata_next = light_lux;
                    `RSSA_IR_LIGHT_CLASS: rdata_next = class_reg;
                    default: err_next = 1'b1;
                endcase
            end
            else
            begin
                case (reg_addr)
                    `RSSA_HR_COMM_TIMEOUT: rdata_next = timeout_reg;
                    `RSSA_HR_BUS_TERM: rdata_next = term_reg;
                    `RSSA_HR_LIGHT_ACTIVE: rdata_next = active_reg;
                    `RSSA_HR_LIGHT_STANDBY: rdata_next = standby_reg;
                    `RSSA_HR_ALARM_MODE: rdata_next = mode_reg;
                    `RSSA_HR_SOURCE_SEL: rdata_next = source_reg;
                    `RSSA_HR_BRIGHTNESS: rdata_next = bright_reg;
                    `RSSA_HR_CALIB_ENABLE: rdata_next = calib_reg;
                    default: err_next = 1'b1;
                endcase
            end
        end
        ack_next = (reg_wr || reg_rd) && !err_next;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timeout_reg <= `RSSA_TIMEOUT_RESET;
            term_reg <= `RSSA_TERM_RESET;
            active_reg <= `RSSA_ACTIVE_RESET;
            standby_reg <= `RSSA_STANDBY_RESET;
            mode_reg <= `RSSA_ALARM_CONT;
            source_reg <= `RSSA_SRC_CO2;
            bright_reg <= `RSSA_BRIGHT_RESET;
            calib_reg <= `RSSA_CALIB_RESET;
            rdata_reg <= 16'h0000;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            timeout_reg <= timeout_next;
            term_reg <= term_next;
            active_reg <= active_next;
            standby_reg <= standby_next;
            mode_reg <= mode_next;
            source_reg <= source_next;
            bright_reg <= bright_next;
            calib_reg <= calib_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
        end
    end

    // Range classification and ambient light class
    always_comb
    begin
        sel_idx = rssa_src_index(source_reg);
        sel_value = meas_value[sel_idx];
        if (rssa_outside(sel_value, range_min[sel_idx], range_max[sel_idx]))
            status_next = RSSA_ST_RED;
        else if (rssa_outside(sel_value, alert_min[sel_idx], alert_max[sel_idx]))
            status_next = RSSA_ST_YELLOW;
        else
            status_next = RSSA_ST_GREEN;
        // Equal to a threshold counts as low intensity
        if (light_lux < standby_reg)
            class_next = `RSSA_CLASS_STANDBY;
        else if (light_lux > active_reg)
            class_next = `RSSA_CLASS_ACTIVE;
        else
            class_next = `RSSA_CLASS_LOW;
    end

    // Half-second divider drives blinking, alarm pulsing and idle seconds
    always_comb
    begin
        half_tick = (half_cnt_reg == HALF_SEC_CYCLES - 32'h0000_0001);
        half_cnt_next = half_tick ? 32'h0000_0000 : half_cnt_reg + 32'h0000_0001;
        blink_next = blink_reg ^ half_tick;
        sec_phase_next = sec_phase_reg ^ half_tick;
        idle_sec_next = idle_sec_reg;
        // Any frame restarts the idle time; saturates so it never wraps
        if (bus_frame_seen)
            idle_sec_next = 16'h0000;
        else if (half_tick && sec_phase_reg && idle_sec_reg != 16'hFFFF)
            idle_sec_next = idle_sec_reg + 16'h0001;
        stale = (timeout_reg != 16'h0000) && (idle_sec_reg > timeout_reg);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_reg <= RSSA_ST_GREEN;
            class_reg <= `RSSA_CLASS_STANDBY;
            half_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
            sec_phase_reg <= 1'b0;
            idle_sec_reg <= 16'h0000;
            alarm_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            class_reg <= class_next;
            half_cnt_reg <= half_cnt_next;
            blink_reg <= blink_next;
            sec_phase_reg <= sec_phase_next;
            idle_sec_reg <= idle_sec_next;
            alarm_reg <= alarm_next;
        end
    end

    // Indicator selection in priority order; one colour at most outside boot
    always_comb
    begin
        led_if.led_on = 3'h0;
        if (bootloader_mode)
        begin
            led_if.led_on[`RSSA_LED_GREEN] = blink_reg;
            led_if.led_on[`RSSA_LED_YELLOW] = ~blink_reg;
            led_if.led_on[`RSSA_LED_RED] = fw_download & blink_reg;
        end
        else if (sensor_lost)
            led_if.led_on[`RSSA_LED_RED] = blink_reg;
        else if (stale)
            led_if.led_on[`RSSA_LED_YELLOW] = blink_reg;
        else
        begin
            case (status_reg)
                RSSA_ST_GREEN: led_if.led_on[`RSSA_LED_GREEN] = 1'b1;
                RSSA_ST_YELLOW: led_if.led_on[`RSSA_LED_YELLOW] = 1'b1;
                RSSA_ST_RED: led_if.led_on[`RSSA_LED_RED] = 1'b1;
                default: led_if.led_on = 3'h0;
            endcase
        end
        // Values above ten clamp to full brightness
        if (bright_reg > 16'(`RSSA_BRIGHT_MAX))
            led_if.bright_steps = `RSSA_BRIGHT_MAX;
        else
            led_if.bright_steps = bright_reg[3:0];
        // Alarm follows range status only; silent while in bootloader
        alarm_due = !bootloader_mode && (status_reg != RSSA_ST_GREEN);
        case (mode_reg)
            `RSSA_ALARM_OFF: alarm_next = 1'b0;
            `RSSA_ALARM_PULSED: alarm_next = alarm_due & blink_reg;
            default: alarm_next = alarm_due;
        endcase
    end

    rssa_led_pwm u_led_pwm (
        .mclk(mclk),
        .reset_n(reset_n),
        .led(led_if.drv),
        .led_green(led_green),
        .led_yellow(led_yellow),
        .led_red(led_red)
    );

    assign reg_rdata = rdata_reg;
    assign reg_ack = ack_reg;
    assign reg_err = err_reg;
    assign alarm_out = alarm_reg;
    assign bus_terminator = term_reg[0];
    assign auto_baseline_calibration = calib_reg[0];
    assign status_code = status_reg;

    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_green_alarm_quiet: assert property (
        status_reg == RSSA_ST_GREEN |=> !alarm_out)
        else $error("Alarm sounding while value in normal band");

    chk_yellow_alarm_on: assert property (
        status_reg == RSSA_ST_YELLOW && mode_reg == `RSSA_ALARM_CONT && !bootloader_mode
        |=> alarm_out)
        else $error("Alarm silent in alert range");

    chk_red_range: assert property (
        rssa_outside(sel_value, range_min[sel_idx], range_max[sel_idx])
        |=> status_reg == RSSA_ST_RED)
        else $error("Out of range value not classed red");

    chk_timeout_blink: assert property (
        stale && !bootloader_mode && !sensor_lost && half_tick
        ##1 stale && !bootloader_mode && !sensor_lost
        |-> led_if.led_on[`RSSA_LED_YELLOW] != $past(led_if.led_on[`RSSA_LED_YELLOW]))
        else $error("Yellow not blinking on bus timeout");

    chk_lost_red_only: assert property (
        sensor_lost && !bootloader_mode
        |-> led_if.led_on[`RSSA_LED_RED] == blink_reg && led_if.led_on[1:0] == 2'h0)
        else $error("Sensor loss not shown as red blink");

    chk_boot_alternate: assert property (
        bootloader_mode && led_if.bright_steps == `RSSA_BRIGHT_MAX
        |=> led_green != led_yellow)
        else $error("Green and yellow not alternating in bootloader");

    chk_boot_red_quiet: assert property (
        bootloader_mode && !fw_download |-> !led_if.led_on[`RSSA_LED_RED])
        else $error("Red lit in bootloader without download");

    chk_alarm_mode_off: assert property (
        mode_reg == `RSSA_ALARM_OFF |=> !alarm_out)
        else $error("Alarm sounding while disabled");

    chk_one_colour: assert property (
        !bootloader_mode |-> $onehot0(led_if.led_on))
        else $error("More than one colour requested");

    chk_light_standby: assert property (
        light_lux < standby_reg |=> class_reg == `RSSA_CLASS_STANDBY)
        else $error("Light below standby not reported as standby");

    chk_thresh_write: assert property (
        reg_wr && !reg_input_space && reg_addr == `RSSA_HR_LIGHT_ACTIVE
        |=> active_reg == $past(reg_wdata) && reg_ack)
        else $error("Active threshold write not taken");

    chk_term_follow: assert property (
        reg_wr && !reg_input_space && reg_addr == `RSSA_HR_BUS_TERM
        |=> bus_terminator == $past(reg_wdata[0]))
        else $error("Terminator does not follow register");
endmodule // rssa_top

// *** src/rssa_cfg.svh ***
// Offsets, reset values and timing for the room sensor status/alarm block.
// Included by bare name; holds definitions only.
// Behaviour
// - Value inside alert limits lights green and keeps alarm silent.
// - Value in alert range lights yellow steadily and sounds alarm.
// - Nonzero timeout and bus idle longer than it blinks yellow.
// - Value outside measurement range lights red and sounds alarm.
// - Lost internal sensor communication blinks red.
// - Bootloader mode flashes green and yellow alternately.
// - Firmware download in bootloader mode also flashes red.
// - Alarm mode register 78: 0 disables, 2 pulses, resets continuous.
// - Register 80 scales indicator brightness 0 to 100 % in 10 % steps.
// - Register 79 selects CO2 by default, or humidity or temperature.
// - Input register 41 reads ambient light in lux.
// - Holding registers 35 and 36 hold active and standby light thresholds.
// - Input register 42 gives standby, active or low intensity class.
// - Holding register 9 switches the bus terminator on or off.
// - Automatic baseline calibration is enabled from reset until disabled.
// - After power-up exactly one colour shows the selected variable status.
`ifndef RSSA_CFG_SVH
`define RSSA_CFG_SVH
// Holding register addresses
`define RSSA_HR_COMM_TIMEOUT 16'h0008
`define RSSA_HR_BUS_TERM 16'h0009
`define RSSA_HR_LIGHT_ACTIVE 16'h0023
`define RSSA_HR_LIGHT_STANDBY 16'h0024
`define RSSA_HR_ALARM_MODE 16'h004E
`define RSSA_HR_SOURCE_SEL 16'h004F
`define RSSA_HR_BRIGHTNESS 16'h0050
`define RSSA_HR_CALIB_ENABLE 16'h0051
// Input register addresses
`define RSSA_IR_LIGHT_LUX 16'h0029
`define RSSA_IR_LIGHT_CLASS 16'h002A
// Reset values and encodings
`define RSSA_TIMEOUT_RESET 16'h0000
`define RSSA_TERM_RESET 16'h0000
`define RSSA_ACTIVE_RESET 16'h01F4
`define RSSA_STANDBY_RESET 16'h0064
`define RSSA_ALARM_OFF 16'h0000
`define RSSA_ALARM_CONT 16'h0001
`define RSSA_ALARM_PULSED 16'h0002
`define RSSA_SRC_CO2 16'h0000
`define RSSA_SRC_RH 16'h0001
`define RSSA_SRC_TEMP 16'h0002
`define RSSA_BRIGHT_RESET 16'h000A
`define RSSA_BRIGHT_MAX 4'hA
`define RSSA_CALIB_RESET 16'h0001
`define RSSA_CLASS_STANDBY 16'h0000
`define RSSA_CLASS_LOW 16'h0001
`define RSSA_CLASS_ACTIVE 16'h0002
// Indicator bit positions
`define RSSA_LED_GREEN 0
`define RSSA_LED_YELLOW 1
`define RSSA_LED_RED 2
// Timing
`define RSSA_CLK_MHZ 125
`define RSSA_HALF_SEC_MS 500
`define RSSA_HALF_SEC_CYCLES (`RSSA_HALF_SEC_MS * 1000 * `RSSA_CLK_MHZ)
`define RSSA_PWM_SLOT_US 10
`define RSSA_PWM_SLOT_CYCLES (`RSSA_PWM_SLOT_US * `RSSA_CLK_MHZ)
`endif

// *** src/rssa_pkg.sv ***
// Types and shared helpers of the room sensor status/alarm block.
// Expects rssa_cfg.svh on the include path.
package rssa_pkg;
`include "rssa_cfg.svh"

    // Range status of the selected measurement, one-hot
    typedef enum logic [2:0] {
        RSSA_ST_GREEN = 3'h1,
        RSSA_ST_YELLOW = 3'h2,
        RSSA_ST_RED = 3'h4
    } rssa_status_type;

    // True when v lies below lo or above hi
    function automatic logic rssa_outside(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        return (v < lo) || (v > hi);
    endfunction

    // Source register to measurement index; unknown codes fall back to CO2
    function automatic logic [1:0] rssa_src_index(input logic [15:0] sel);
        logic [1:0] idx;
        idx = 2'h0;
        if (sel == `RSSA_SRC_RH)
            idx = 2'h1;
        else if (sel == `RSSA_SRC_TEMP)
            idx = 2'h2;
        return idx;
    endfunction
endpackage

// *** src/rssa_led_if.sv ***
// Carrier between status logic and indicator driver.
// Both ends run on mclk.
`timescale 1ns/1ps
interface rssa_led_if;
    logic [2:0] led_on;
    logic [3:0] bright_steps;
    modport ctrl (output led_on, output bright_steps);
    modport drv (input led_on, input bright_steps);
endinterface

// *** src/rssa_led_pwm.sv ***
// Indicator driver: brightness PWM in ten slots, registered LED pins.
// Assumes requests and brightness come from logic on mclk.
`timescale 1ns/1ps
`include "rssa_cfg.svh"
module rssa_led_pwm (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Indicator requests
    rssa_led_if.drv led,
    // Indicator pins
    output logic led_green,
    output logic led_yellow,
    output logic led_red
);
    import rssa_pkg::*;

    logic [15:0] slot_cnt_reg, slot_cnt_next;
    logic [3:0] slot_reg, slot_next;
    logic [2:0] leds_reg, leds_next;
    logic slot_tick;

    // Slot divider; ten slots give 10 % brightness steps
    always_comb
    begin
        slot_tick = (slot_cnt_reg == 16'(`RSSA_PWM_SLOT_CYCLES - 1));
        slot_cnt_next = slot_tick ? 16'h0000 : slot_cnt_reg + 16'h0001;
        slot_next = slot_reg;
        if (slot_tick)
            slot_next = (slot_reg == `RSSA_BRIGHT_MAX - 4'h1) ? 4'h0 : slot_reg + 4'h1;
        leds_next = led.led_on & {3{slot_reg < led.bright_steps}};
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slot_cnt_reg <= 16'h0000;
            slot_reg <= 4'h0;
            leds_reg <= 3'h0;
        end
        else
        begin
            slot_cnt_reg <= slot_cnt_next;
            slot_reg <= slot_next;
            leds_reg <= leds_next;
        end
    end

    assign led_green = leds_reg[`RSSA_LED_GREEN];
    assign led_yellow = leds_reg[`RSSA_LED_YELLOW];
    assign led_red = leds_reg[`RSSA_LED_RED];

    // Zero brightness keeps every LED dark
    chk_pwm_dark_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        led.bright_steps == 4'h0 |=> !led_green && !led_yellow && !led_red)
        else $error("LED lit at zero brightness");

    // Full brightness passes a request through every slot
    chk_pwm_full_on: assert property (@(posedge mclk) disable iff (!reset_n)
        led.bright_steps == `RSSA_BRIGHT_MAX && led.led_on[`RSSA_LED_GREEN] |=> led_green)
        else $error("Green dark at full brightness");
endmodule // rssa_led_pwm

// *** bench/rssa_master.sv ***
// Register-port master standing in for the bus frame decoder.
// Assumes the device takes requests on rising mclk.
`timescale 1ns/1ps
module rssa_master (
    // Clock
    input wire logic mclk,
    // Requests
    output logic reg_rd,
    output logic reg_wr,
    output logic reg_input_space,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic bus_frame_seen,
    // Answers
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err
);
    // Idle port at time zero
    initial
    begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_input_space = 1'b0;
        reg_addr = 16'hffff;
        reg_wdata = 16'hffff;
        bus_frame_seen = 1'b0;
    end

    // One frame: request held over the taking edge, answer read just after that same edge
    task automatic xfer(input logic wr, input logic sp, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic ack, output logic err);
        @(posedge mclk);
        #1;
        reg_wr = wr;
        reg_rd = ~wr;
        reg_input_space = sp;
        reg_addr = a;
        reg_wdata = d;
        bus_frame_seen = 1'b1;
        @(posedge mclk);
        #1;
        q = reg_rdata;
        ack = reg_ack;
        err = reg_err;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bus_frame_seen = 1'b0;
        // Released address and write data never keep the old value; reg_input_space keeps it
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // rssa_master

// *** bench/rssa_bench.sv ***
// Self-checking bench of the room sensor status and alarm block.
// Assumes a blink half period of 8 cycles and rssa_master on the port.
`timescale 1ns/1ps
module rssa_bench;
    import rssa_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_rd, reg_wr, reg_input_space, bus_frame_seen, reg_ack, reg_err, ack, err;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, q;
    logic [15:0] light_lux = 16'h0050;
    logic [2:0][15:0] meas_value = {3{16'h0300}};
    logic sensor_lost = 1'b0;
    logic bootloader_mode = 1'b0;
    logic fw_download = 1'b0;
    logic led_green, led_yellow, led_red, alarm_out, bus_terminator, auto_baseline_calibration;
    rssa_status_type status_code;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int ng, ny, nr, na;
    localparam logic [15:0] HA [6] = '{16'h0009, 16'h0023, 16'h0024, 16'h004e, 16'h004f, 16'h0050};
    localparam logic [15:0] HR [6] = '{16'h0000, 16'h01f4, 16'h0064, 16'h0001, 16'h0000, 16'h000a};
    localparam logic [15:0] WV [6] = '{16'h0001, 16'h0300, 16'h0080, 16'h0000, 16'h0001, 16'h0007};
    localparam logic [15:0] LX [5] = '{16'h0050, 16'h0080, 16'h0200, 16'h0300, 16'h0301};
    localparam logic [15:0] LC [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0002};
    localparam logic [2:0] SC [4] = '{3'h1, 3'h4, 3'h2, 3'h1};

    // Short blink time keeps each blink check to a few dozen cycles
    rssa_top #(.HALF_SEC_CYCLES(8)) u_dut (.mclk(mclk), .reset_n(reset_n),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_input_space(reg_input_space),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .bus_frame_seen(bus_frame_seen),
        .meas_value(meas_value), .alert_min({3{16'h0200}}), .alert_max({3{16'h0400}}),
        .range_min({3{16'h0100}}), .range_max({3{16'h0800}}), .light_lux(light_lux),
        .sensor_lost(sensor_lost), .bootloader_mode(bootloader_mode),
        .fw_download(fw_download), .led_green(led_green), .led_yellow(led_yellow),
        .led_red(led_red), .alarm_out(alarm_out), .bus_terminator(bus_terminator),
        .auto_baseline_calibration(auto_baseline_calibration), .status_code(status_code));
    rssa_master u_master (.mclk(mclk), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_input_space(reg_input_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .bus_frame_seen(bus_frame_seen), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err));

    // Clock and hang guard
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        u_master.xfer(1'b1, 1'b0, a, d, q, ack, err);
        chk("write ack", 16'h0001, {15'h0, ack});
    endtask
    task automatic rd(input logic sp, input logic [15:0] a, input logic [15:0] e);
        u_master.xfer(1'b0, sp, a, 16'h0000, q, ack, err);
        chk("read data", e, q);
    endtask
    // Steady colour, pins and alarm once the pipeline has settled
    task automatic colour(input logic [2:0] e, input logic al);
        repeat (3) @(posedge mclk);
        #1;
        chk("status", {13'h0, e}, {13'h0, status_code});
        chk("leds", {13'h0, e}, {13'h0, led_red, led_yellow, led_green});
        chk("alarm", {15'h0, al}, {15'h0, alarm_out});
    endtask
    // High cycles of each pin over a window
    task automatic watch(input int n);
        ng = 0;
        ny = 0;
        nr = 0;
        na = 0;
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            ng += led_green;
            ny += led_yellow;
            nr += led_red;
            na += alarm_out;
        end
    endtask
    task automatic bl(input string n, input int c, input int w);
        chk(n, 16'h0001, {15'h0, c > 0 && c < w});
    endtask

    initial
    begin
        repeat (8) @(posedge mclk);
        #1;
        chk("calibration in reset", 16'h0001, {15'h0, auto_baseline_calibration});
        chk("pins in reset", 16'h0000, {12'h0, led_red, led_yellow, led_green, alarm_out});
        repeat (8) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        colour(3'h1, 1'b0);
        rd(1'b0, 16'h0008, 16'h0000);
        for (int i = 0; i < 6; i++)
            rd(1'b0, HA[i], HR[i]);
        for (int i = 0; i < 6; i++)
        begin
            wr(HA[i], WV[i]);
            rd(1'b0, HA[i], WV[i]);
        end
        // Only this device terminates its segment end
        chk("terminator", 16'h0001, {15'h0, bus_terminator});
        u_master.xfer(1'b1, 1'b1, 16'h0029, 16'h1234, q, ack, err);
        chk("input space write", 16'h0001, {15'h0, err});
        u_master.xfer(1'b0, 1'b0, 16'h0077, 16'h0000, q, ack, err);
        chk("unmapped read", 16'h0001, {15'h0, err});
        // Light level and class against thresholds 0x0300 and 0x0080
        for (int i = 0; i < 5; i++)
        begin
            light_lux = LX[i];
            rd(1'b1, 16'h0029, LX[i]);
            rd(1'b1, 16'h002a, LC[i]);
        end
        // Site without clean-air periods turns self-calibration off
        wr(16'h0051, 16'h0000);
        chk("calibration off", 16'h0000, {15'h0, auto_baseline_calibration});
        wr(16'h004e, 16'h0001);
        wr(16'h0050, 16'h000a);
        meas_value = {16'h0500, 16'h0900, 16'h0300};
        for (int s = 0; s < 4; s++)
        begin
            wr(16'h004f, 16'(s));
            colour(SC[s], s == 1 || s == 2);
        end
        meas_value[0] = 16'h0080;
        colour(3'h4, 1'b1);
        wr(16'h004e, 16'h0000);
        colour(3'h4, 1'b0);
        wr(16'h004e, 16'h0002);
        watch(40);
        bl("pulsed alarm", na, 40);
        wr(16'h004e, 16'h0001);
        watch(16);
        chk("continuous alarm", 16'h0010, 16'(na));
        meas_value[0] = 16'h0300;
        sensor_lost = 1'b1;
        watch(40);
        bl("red blink", nr, 40);
        chk("others dark", 16'h0000, 16'(ng + ny));
        sensor_lost = 1'b0;
        wr(16'h0008, 16'h0001);
        repeat (80) @(posedge mclk);
        watch(40);
        bl("yellow blink", ny, 40);
        chk("green dark", 16'h0000, 16'(ng + nr));
        rd(1'b0, 16'h0008, 16'h0001);
        colour(3'h1, 1'b0);
        wr(16'h0008, 16'h0000);
        bootloader_mode = 1'b1;
        watch(40);
        bl("green flash", ng, 40);
        chk("alternate", 16'h0028, 16'(ng + ny + nr));
        fw_download = 1'b1;
        watch(40);
        bl("red flash", nr, 40);
        bootloader_mode = 1'b0;
        fw_download = 1'b0;
        wr(16'h0050, 16'h0000);
        watch(2500);
        chk("dark at zero", 16'h0000, 16'(ng));
        wr(16'h0050, 16'h0005);
        watch(12500);
        chk("half brightness", 16'h186a, 16'(ng));
        wrap_up();
    end
endmodule // rssa_bench
